// *** common/cdic_params.svh ***
// constants of the clock distribution and interface clock control block
// assumes inclusion by bare name from the package, the top module and the verification files
`ifndef CDIC_PARAMS_SVH
`define CDIC_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define CDIC_OFS_IFACE_CLK 6'h01
`define CDIC_OFS_TX_PATH 6'h13
`define CDIC_OFS_PLL_CLK 6'h15
`define CDIC_OFS_CLKOUT_SRC 6'h16

////////////////////////////////////////////////////////////////////////////////
// field positions
`define CDIC_BIT_CLK_MODE_HI 7
`define CDIC_BIT_CLK_MODE_LO 5
`define CDIC_BIT_DUPLEX 4
`define CDIC_BIT_WIDTH 3
`define CDIC_BIT_AUX_EN 2
`define CDIC_BIT_DCLK_INV 1
`define CDIC_BIT_TX_FALL 5
`define CDIC_BIT_INTERP_HI 1
`define CDIC_BIT_INTERP_LO 0
`define CDIC_BIT_BYPASS 7
`define CDIC_BIT_ADC_DIV 5
`define CDIC_BIT_ALT_TIMING 4
`define CDIC_BIT_DIV5 3
`define CDIC_BIT_MULT_HI 2
`define CDIC_BIT_MULT_LO 0
`define CDIC_BIT_AUX_SRC 5

////////////////////////////////////////////////////////////////////////////////
// reset values and encodings
`define CDIC_RST_FIELD 8'h00
`define CDIC_CLK_MODE_DEFAULT 3'h0
`define CDIC_CLK_MODE_OPTIONAL 3'h1
`define CDIC_CLK_MODE_CLONE 3'h2
`define CDIC_INTERP_X1 2'h0
`define CDIC_INTERP_X2 2'h1
`define CDIC_INTERP_X4 2'h2
`define CDIC_MULT_X1 3'h0
`define CDIC_MULT_X2 3'h1
`define CDIC_MULT_X4 3'h2
`define CDIC_MULT_X8 3'h3
`define CDIC_MULT_X16 3'h4

////////////////////////////////////////////////////////////////////////////////
// division ratios, counted in input clock edges per half period of the divided clock
`define CDIC_DIV_ONE 3'h1
`define CDIC_DIV_TWO 3'h2
`define CDIC_DIV_FOUR 3'h4
`define CDIC_DIV_FIVE 3'h5

`endif

// *** common/cdic_pkg.sv ***
// types of the clock distribution and interface clock control block
// assumes cdic_params.svh on the include path
`include "cdic_params.svh"

package cdic_pkg;

	typedef enum logic [3:0] {
		CDIC_MODE_1 = 4'b0001,
		CDIC_MODE_2 = 4'b0010,
		CDIC_MODE_4 = 4'b0100,
		CDIC_MODE_5 = 4'b0101,
		CDIC_MODE_7 = 4'b0111,
		CDIC_MODE_8 = 4'b1000,
		CDIC_MODE_10 = 4'b1010
	} cdic_mode_t;

	typedef struct packed {
		logic [2:0] clk_mode;
		logic full_duplex;
		logic narrow_bus;
		logic aux_clock_enable;
		logic data_clock_invert;
		logic tx_sample_falling;
		logic [1:0] interp;
		logic pll_bypass;
		logic adc_div;
		logic alt_timing;
		logic divide_by_five_enable;
		logic [2:0] pll_mult;
		logic aux_clock_source_select;
	} cdic_cfg_t;

	typedef struct packed {
		logic o;
		logic oe;
	} cdic_pin_drv_t;

endpackage : cdic_pkg

// *** verilog/cdic_clk_div.sv ***
// clock divider working on a sampled clock level, 50 percent duty for any ratio
// assumes clk_in_i is synchronous to mclk_i and much slower than it
`timescale 1ns/1ps

module cdic_clk_div #(
	parameter int CNT_W = 3
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// clock in and ratio
	input wire logic clk_in_i,
	input wire logic [CNT_W-1:0] ratio_i,
	// divided clock
	output logic clk_o
);

	if (CNT_W < 3) begin : g_bad_width
		$error("cdic_clk_div: CNT_W must be at least 3");
	end

	logic prev;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic edge_seen;

	assign edge_seen = clk_in_i != prev;
	assign next_cnt = cnt + {{(CNT_W-1){1'b0}}, 1'b1};

	////////////////////////////////////////////////////////////////////////////////
	// both edges counted, output toggles every ratio edges
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			prev <= 1'b0;
			cnt <= '0;
			clk_o <= 1'b0;
		end else begin
			prev <= clk_in_i;
			if (edge_seen) begin
				if (next_cnt >= ratio_i) begin
					cnt <= '0;
					clk_o <= !clk_o;
				end else begin
					cnt <= next_cnt;
				end
			end
		end
	end

endmodule : cdic_clk_div

// *** verilog/cdic_glitchless_mux.sv ***
// two-input clock select that only switches while the output and the newly selected side are low
// assumes both clock levels are synchronous to mclk_i
`timescale 1ns/1ps

module cdic_glitchless_mux (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// clock levels and select
	input wire logic clk_a_i,
	input wire logic clk_b_i,
	input wire logic sel_i,
	// selected clock
	output logic clk_o
);

	logic cur;
	logic target_low;

	assign target_low = sel_i ? !clk_b_i : !clk_a_i;

	////////////////////////////////////////////////////////////////////////////////
	// hold low across a change so no runt pulse escapes
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cur <= 1'b0;
			clk_o <= 1'b0;
		end else if (sel_i != cur) begin
			clk_o <= 1'b0;
			if (!clk_o && target_low) begin
				cur <= sel_i;
			end
		end else begin
			clk_o <= cur ? clk_b_i : clk_a_i;
		end
	end

endmodule : cdic_glitchless_mux

// *** verilog/cdic_top.sv ***
// clock distribution and interface pin control of the converter front end
// assumes reference and pll clocks arrive as levels synchronous to mclk_i,
// and that the serial port engine presents one-cycle register strobes
`timescale 1ns/1ps
`include "cdic_params.svh"

module cdic_top
	import cdic_pkg::*;
#(
	parameter int ADDR_W = 6,
	parameter int DIV_W = 3
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// register port from the serial interface
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// reference clocks and pll
	input wire logic rx_reference_clock_i,
	input wire logic tx_reference_clock_i,
	input wire logic pll_clk_i,
	output logic [4:0] pll_factor_o,
	output logic pll_bypass_o,
	output logic ref_tie_o,
	// converter clocks
	output logic dac_update_clk_o,
	output logic adc_clk_o,
	output logic tx_data_latch_o,
	output logic cfg_error_o,
	// txrx_select_pin
	input wire logic txrx_select_pin_i,
	output logic txrx_select_pin_o,
	output logic txrx_select_pin_oe_o,
	// aux_clock_pin
	output logic aux_clock_pin_o,
	output logic aux_clock_pin_oe_o,
	// data_clock_pin
	output logic data_clock_pin_o,
	output logic data_clock_pin_oe_o
);

	if (ADDR_W < 5 || DIV_W < 3) begin : g_bad_param
		$error("cdic_top: ADDR_W must be at least 5 and DIV_W at least 3");
	end

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	cdic_cfg_t cfg;
	cdic_mode_t mode;
	cdic_mode_t next_mode;
	cdic_pin_drv_t next_aux;
	logic interleaved;
	logic tied;
	logic transmit;
	logic rx_ref_eff;
	logic pll_sel_clk;
	logic sys_clk;
	logic rx_path_clk;
	logic adc_clk;
	logic tx_data_clk;
	logic aux_src_clk;
	logic tx_clk_prev;
	logic rx_clk_prev;
	logic tx_sync;
	logic rx_sync;
	logic [DIV_W-1:0] div5_ratio;
	logic [DIV_W-1:0] adc_ratio;
	logic [DIV_W-1:0] tx_ratio;
	logic [DIV_W-1:0] next_tx_ratio;
	logic [7:0] next_rdata;

	////////////////////////////////////////////////////////////////////////////////
	// register writes
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cfg <= '0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				ADDR_W'(`CDIC_OFS_IFACE_CLK): begin
					cfg.clk_mode <= reg_wdata_i[`CDIC_BIT_CLK_MODE_HI:`CDIC_BIT_CLK_MODE_LO];
					cfg.full_duplex <= reg_wdata_i[`CDIC_BIT_DUPLEX];
					cfg.narrow_bus <= reg_wdata_i[`CDIC_BIT_WIDTH];
					cfg.aux_clock_enable <= reg_wdata_i[`CDIC_BIT_AUX_EN];
					cfg.data_clock_invert <= reg_wdata_i[`CDIC_BIT_DCLK_INV];
				end
				ADDR_W'(`CDIC_OFS_TX_PATH): begin
					cfg.tx_sample_falling <= reg_wdata_i[`CDIC_BIT_TX_FALL];
					cfg.interp <= reg_wdata_i[`CDIC_BIT_INTERP_HI:`CDIC_BIT_INTERP_LO];
				end
				ADDR_W'(`CDIC_OFS_PLL_CLK): begin
					cfg.pll_bypass <= reg_wdata_i[`CDIC_BIT_BYPASS];
					cfg.adc_div <= reg_wdata_i[`CDIC_BIT_ADC_DIV];
					cfg.alt_timing <= reg_wdata_i[`CDIC_BIT_ALT_TIMING];
					cfg.divide_by_five_enable <= reg_wdata_i[`CDIC_BIT_DIV5];
					cfg.pll_mult <= reg_wdata_i[`CDIC_BIT_MULT_HI:`CDIC_BIT_MULT_LO];
				end
				ADDR_W'(`CDIC_OFS_CLKOUT_SRC): begin
					cfg.aux_clock_source_select <= reg_wdata_i[`CDIC_BIT_AUX_SRC];
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register reads, unmapped offsets read zero
	always_comb begin
		next_rdata = `CDIC_RST_FIELD;
		case (reg_addr_i)
			ADDR_W'(`CDIC_OFS_IFACE_CLK): begin
				next_rdata[`CDIC_BIT_CLK_MODE_HI:`CDIC_BIT_CLK_MODE_LO] = cfg.clk_mode;
				next_rdata[`CDIC_BIT_DUPLEX] = cfg.full_duplex;
				next_rdata[`CDIC_BIT_WIDTH] = cfg.narrow_bus;
				next_rdata[`CDIC_BIT_AUX_EN] = cfg.aux_clock_enable;
				next_rdata[`CDIC_BIT_DCLK_INV] = cfg.data_clock_invert;
			end
			ADDR_W'(`CDIC_OFS_TX_PATH): begin
				next_rdata[`CDIC_BIT_TX_FALL] = cfg.tx_sample_falling;
				next_rdata[`CDIC_BIT_INTERP_HI:`CDIC_BIT_INTERP_LO] = cfg.interp;
			end
			ADDR_W'(`CDIC_OFS_PLL_CLK): begin
				next_rdata[`CDIC_BIT_BYPASS] = cfg.pll_bypass;
				next_rdata[`CDIC_BIT_ADC_DIV] = cfg.adc_div;
				next_rdata[`CDIC_BIT_ALT_TIMING] = cfg.alt_timing;
				next_rdata[`CDIC_BIT_DIV5] = cfg.divide_by_five_enable;
				next_rdata[`CDIC_BIT_MULT_HI:`CDIC_BIT_MULT_LO] = cfg.pll_mult;
			end
			ADDR_W'(`CDIC_OFS_CLKOUT_SRC): begin
				next_rdata[`CDIC_BIT_AUX_SRC] = cfg.aux_clock_source_select;
			end
			default: begin
				next_rdata = `CDIC_RST_FIELD;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= `CDIC_RST_FIELD;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// clock mode decode
	always_comb begin
		next_mode = CDIC_MODE_1;
		if (cfg.full_duplex) begin
			next_mode = (cfg.clk_mode == `CDIC_CLK_MODE_OPTIONAL) ? CDIC_MODE_2 : CDIC_MODE_1;
		end else if (cfg.clk_mode == `CDIC_CLK_MODE_CLONE) begin
			next_mode = CDIC_MODE_10;
		end else if (cfg.narrow_bus) begin
			next_mode = (cfg.clk_mode == `CDIC_CLK_MODE_OPTIONAL) ? CDIC_MODE_8 : CDIC_MODE_7;
		end else begin
			next_mode = (cfg.clk_mode == `CDIC_CLK_MODE_OPTIONAL) ? CDIC_MODE_5 : CDIC_MODE_4;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			mode <= CDIC_MODE_4;
		end else begin
			mode <= next_mode;
		end
	end

	always_comb begin
		case (mode)
			CDIC_MODE_1, CDIC_MODE_2, CDIC_MODE_7, CDIC_MODE_8, CDIC_MODE_10: interleaved = 1'b1;
			default: interleaved = 1'b0;
		endcase
	end

	always_comb begin
		case (mode)
			CDIC_MODE_2, CDIC_MODE_5, CDIC_MODE_8: tied = 1'b1;
			default: tied = 1'b0;
		endcase
	end

	// half duplex direction comes from the back end, high means transmit
	assign transmit = mode == CDIC_MODE_1 || mode == CDIC_MODE_2 || txrx_select_pin_i;

	////////////////////////////////////////////////////////////////////////////////
	// pll control and system clock
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pll_factor_o <= 5'h01;
			pll_bypass_o <= 1'b0;
			ref_tie_o <= 1'b0;
		end else begin
			case (cfg.pll_mult)
				`CDIC_MULT_X1: pll_factor_o <= 5'h01;
				`CDIC_MULT_X2: pll_factor_o <= 5'h02;
				`CDIC_MULT_X4: pll_factor_o <= 5'h04;
				`CDIC_MULT_X8: pll_factor_o <= 5'h08;
				`CDIC_MULT_X16: pll_factor_o <= 5'h10;
				default: pll_factor_o <= 5'h01;
			endcase
			pll_bypass_o <= cfg.pll_bypass;
			ref_tie_o <= tied;
		end
	end

	// tied references feed the rx side from the tx reference
	cdic_glitchless_mux u_ref_tie (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.clk_a_i(rx_reference_clock_i),
		.clk_b_i(tx_reference_clock_i),
		.sel_i(tied),
		.clk_o(rx_ref_eff)
	);

	cdic_glitchless_mux u_bypass (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.clk_a_i(pll_clk_i),
		.clk_b_i(tx_reference_clock_i),
		.sel_i(cfg.pll_bypass),
		.clk_o(pll_sel_clk)
	);

	assign div5_ratio = cfg.divide_by_five_enable ? DIV_W'(`CDIC_DIV_FIVE) : DIV_W'(`CDIC_DIV_ONE);

	cdic_clk_div #(.CNT_W(DIV_W)) u_div5 (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.clk_in_i(pll_sel_clk),
		.ratio_i(div5_ratio),
		.clk_o(sys_clk)
	);

	////////////////////////////////////////////////////////////////////////////////
	// receive path clock
	cdic_glitchless_mux u_rx_src (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.clk_a_i(rx_ref_eff),
		.clk_b_i(sys_clk),
		.sel_i(cfg.alt_timing),
		.clk_o(rx_path_clk)
	);

	assign adc_ratio = cfg.adc_div ? DIV_W'(`CDIC_DIV_TWO) : DIV_W'(`CDIC_DIV_ONE);

	cdic_clk_div #(.CNT_W(DIV_W)) u_adc_div (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.clk_in_i(rx_path_clk),
		.ratio_i(adc_ratio),
		.clk_o(adc_clk)
	);

	////////////////////////////////////////////////////////////////////////////////
	// transmit data clock
	always_comb begin
		next_tx_ratio = DIV_W'(`CDIC_DIV_ONE);
		case (cfg.interp)
			`CDIC_INTERP_X2: next_tx_ratio = interleaved ? DIV_W'(`CDIC_DIV_ONE) : DIV_W'(`CDIC_DIV_TWO);
			`CDIC_INTERP_X4: next_tx_ratio = interleaved ? DIV_W'(`CDIC_DIV_TWO) : DIV_W'(`CDIC_DIV_FOUR);
			default: next_tx_ratio = DIV_W'(`CDIC_DIV_ONE);
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			tx_ratio <= DIV_W'(`CDIC_DIV_ONE);
			cfg_error_o <= 1'b0;
		end else begin
			tx_ratio <= next_tx_ratio;
			cfg_error_o <= interleaved && cfg.interp != `CDIC_INTERP_X2 && cfg.interp != `CDIC_INTERP_X4;
		end
	end

	cdic_clk_div #(.CNT_W(DIV_W)) u_tx_div (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.clk_in_i(sys_clk),
		.ratio_i(tx_ratio),
		.clk_o(tx_data_clk)
	);

	////////////////////////////////////////////////////////////////////////////////
	// aux pin source
	cdic_glitchless_mux u_aux_src (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.clk_a_i(rx_ref_eff),
		.clk_b_i(sys_clk),
		.sel_i(cfg.aux_clock_source_select),
		.clk_o(aux_src_clk)
	);

	////////////////////////////////////////////////////////////////////////////////
	// sync markers, one toggle per data clock rising edge
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			tx_clk_prev <= 1'b0;
			rx_clk_prev <= 1'b0;
			tx_sync <= 1'b0;
			rx_sync <= 1'b0;
		end else begin
			tx_clk_prev <= tx_data_clk;
			rx_clk_prev <= adc_clk;
			if (tx_data_clk && !tx_clk_prev) begin
				tx_sync <= !tx_sync;
			end
			if (adc_clk && !rx_clk_prev) begin
				rx_sync <= !rx_sync;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// converter clocks and tx latch strobe
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			dac_update_clk_o <= 1'b0;
			adc_clk_o <= 1'b0;
			tx_data_latch_o <= 1'b0;
		end else begin
			dac_update_clk_o <= sys_clk;
			adc_clk_o <= adc_clk;
			if (cfg.tx_sample_falling) begin
				tx_data_latch_o <= !tx_data_clk && tx_clk_prev;
			end else begin
				tx_data_latch_o <= tx_data_clk && !tx_clk_prev;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interface pins
	always_comb begin
		next_aux = '0;
		case (mode)
			CDIC_MODE_1: begin
				next_aux.o = aux_src_clk ^ cfg.aux_clock_enable;
				next_aux.oe = 1'b1;
			end
			CDIC_MODE_2: begin
				next_aux.o = rx_sync;
				next_aux.oe = 1'b1;
			end
			default: begin
				next_aux.o = cfg.aux_clock_enable && aux_src_clk;
				next_aux.oe = cfg.aux_clock_enable;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			txrx_select_pin_o <= 1'b0;
			txrx_select_pin_oe_o <= 1'b0;
			aux_clock_pin_o <= 1'b0;
			aux_clock_pin_oe_o <= 1'b0;
			data_clock_pin_o <= 1'b0;
			data_clock_pin_oe_o <= 1'b0;
		end else begin
			txrx_select_pin_o <= cfg.full_duplex && tx_sync;
			txrx_select_pin_oe_o <= cfg.full_duplex;
			aux_clock_pin_o <= next_aux.o;
			aux_clock_pin_oe_o <= next_aux.oe;
			data_clock_pin_o <= (transmit ? tx_data_clk : adc_clk) ^ cfg.data_clock_invert;
			data_clock_pin_oe_o <= 1'b1;
		end
	end

endmodule : cdic_top

// *** verification/cdic_bb_model.sv ***
// back end model on the first interface pin
// assumes the design output enable marks when the device drives the pin
`timescale 1ns/1ps

module cdic_bb_model (
	// clock
	input wire logic mclk_i,
	// direction wanted by the bench, 1 = transmit
	input wire logic tx_req_i,
	// device side of the pin
	input wire logic pin_o_i,
	input wire logic pin_oe_i,
	// resolved pin level
	output logic pin_i_o
);
	logic dir;

	always_ff @(posedge mclk_i) begin
		dir <= tx_req_i;
	end

	assign pin_i_o = pin_oe_i ? pin_o_i : dir;
endmodule : cdic_bb_model

// *** verification/cdic_top_sva.sv ***
// port assertions of the clock control top
// assumes bind to cdic_top and one-cycle register strobes
`timescale 1ns/1ps
`include "cdic_params.svh"

module cdic_top_sva
	import cdic_pkg::*;
#(
	parameter int ADDR_W = 6,
	parameter int DIV_W = 3
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic reg_wr_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	// watched outputs
	input wire logic [4:0] pll_factor_o,
	input wire logic pll_bypass_o,
	input wire logic ref_tie_o,
	input wire logic tx_data_latch_o,
	input wire logic cfg_error_o,
	input wire logic txrx_select_pin_oe_o,
	input wire logic aux_clock_pin_oe_o,
	input wire logic data_clock_pin_o,
	input wire logic data_clock_pin_oe_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	////////////////////////////////////////////////////////////////////////////////
	// shadow of written fields and quiet time since last write
	logic [7:0] sh_if, sh_tx, sh_pll;
	logic [2:0] quiet;
	logic settled, ilv, x1;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sh_if <= 8'h00;
			sh_tx <= 8'h00;
			sh_pll <= 8'h00;
		end else if (reg_wr_i) begin
			if (reg_addr_i == `CDIC_OFS_IFACE_CLK) sh_if <= reg_wdata_i;
			if (reg_addr_i == `CDIC_OFS_TX_PATH) sh_tx <= reg_wdata_i;
			if (reg_addr_i == `CDIC_OFS_PLL_CLK) sh_pll <= reg_wdata_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || reg_wr_i) quiet <= 3'h0;
		else if (quiet != 3'h7) quiet <= quiet + 3'h1;
	end

	assign settled = quiet == 3'h7;
	assign ilv = sh_if[4] | sh_if[3] | (sh_if[7:5] == 3'h2);
	assign x1 = sh_tx[1:0] == 2'h0 || sh_tx[1:0] == 2'h3;

	////////////////////////////////////////////////////////////////////////////////
	// properties
	property p_rst; $rose(rst_n_i) |-> pll_factor_o == 5'h01 && reg_rdata_o == 8'h00 && !ref_tie_o; endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	property p_fac; settled && sh_pll[2:0] <= 3'h4 |-> pll_factor_o == 5'h01 << sh_pll[2:0]; endproperty
	a_fac: assert property (p_fac) else $error("pll factor wrong");
	property p_byp; settled |-> pll_bypass_o == sh_pll[7]; endproperty
	a_byp: assert property (p_byp) else $error("bypass wrong");
	property p_tie; settled |-> ref_tie_o == (sh_if[7:5] == 3'h1); endproperty
	a_tie: assert property (p_tie) else $error("reference tie wrong");
	property p_err; settled |-> cfg_error_o == (ilv && x1); endproperty
	a_err: assert property (p_err) else $error("config error flag wrong");
	property p_sel; settled |-> txrx_select_pin_oe_o == sh_if[4]; endproperty
	a_sel: assert property (p_sel) else $error("first pin direction wrong");
	property p_aux; settled |-> aux_clock_pin_oe_o == (sh_if[4] | sh_if[2]); endproperty
	a_aux: assert property (p_aux) else $error("second pin enable wrong");
	property p_dcl; $rose(rst_n_i) |-> ##2 data_clock_pin_oe_o [*8]; endproperty
	a_dcl: assert property (p_dcl) else $error("third pin not driven");
	property p_lat; tx_data_latch_o |=> !tx_data_latch_o; endproperty
	a_lat: assert property (p_lat) else $error("latch pulse too long");
	property p_edg; settled && sh_if[4] && !sh_if[1] && tx_data_latch_o |->
		(sh_tx[5] ? $fell(data_clock_pin_o) : $rose(data_clock_pin_o)); endproperty
	a_edg: assert property (p_edg) else $error("latch on wrong clock edge");
	property p_rel; $rose(rst_n_i) |=> !cfg_error_o && !aux_clock_pin_oe_o && !txrx_select_pin_oe_o; endproperty
	a_rel: assert property (p_rel) else $error("outputs driven right after reset");
endmodule : cdic_top_sva

bind cdic_top cdic_top_sva #(.ADDR_W(ADDR_W), .DIV_W(DIV_W)) u_sva (.mclk_i, .rst_n_i, .reg_wr_i, .reg_addr_i,
	.reg_wdata_i, .reg_rdata_o, .pll_factor_o, .pll_bypass_o, .ref_tie_o, .tx_data_latch_o, .cfg_error_o,
	.txrx_select_pin_oe_o, .aux_clock_pin_oe_o, .data_clock_pin_o, .data_clock_pin_oe_o);

// *** verification/cdic_tb_top.sv ***
// self-checking bench of the clock control top
// assumes design, package, model and checker compiled before it
`timescale 1ns/1ps
`include "cdic_params.svh"

module cdic_tb_top;
	logic mclk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, tx_req = 1'b0;
	logic [5:0] reg_addr_i = 6'h00;
	logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
	logic rx_reference_clock_i = 1'b0, tx_reference_clock_i = 1'b0, pll_clk_i = 1'b0;
	logic [4:0] pll_factor_o, prv = 5'h00;
	logic pll_bypass_o, ref_tie_o, dac_update_clk_o, adc_clk_o, tx_data_latch_o, cfg_error_o;
	logic txrx_select_pin_i, txrx_select_pin_o, txrx_select_pin_oe_o;
	logic aux_clock_pin_o, aux_clock_pin_oe_o, data_clock_pin_o, data_clock_pin_oe_o;
	int errors = 0, cmp_count = 0, cyc = 0, tick = 0;
	int n_dac, n_adc, n_lat, n_aux, n_dcp, n_sel, n_eq, n_ar;

	cdic_top dut (.mclk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
		.rx_reference_clock_i, .tx_reference_clock_i, .pll_clk_i, .pll_factor_o, .pll_bypass_o, .ref_tie_o,
		.dac_update_clk_o, .adc_clk_o, .tx_data_latch_o, .cfg_error_o, .txrx_select_pin_i, .txrx_select_pin_o,
		.txrx_select_pin_oe_o, .aux_clock_pin_o, .aux_clock_pin_oe_o, .data_clock_pin_o, .data_clock_pin_oe_o);
	cdic_bb_model bb (.mclk_i, .tx_req_i(tx_req), .pin_o_i(txrx_select_pin_o), .pin_oe_i(txrx_select_pin_oe_o),
		.pin_i_o(txrx_select_pin_i));

	////////////////////////////////////////////////////////////////////////////////
	// clock, references, edge counters and timeout
	always #5 mclk_i = !mclk_i;

	always @(negedge mclk_i) begin
		tick++;
		if (tick % 10 == 0) tx_reference_clock_i <= !tx_reference_clock_i;
		if (tick % 12 == 0) rx_reference_clock_i <= !rx_reference_clock_i;
		if (tick % 4 == 0) pll_clk_i <= !pll_clk_i;
	end

	always @(posedge mclk_i) begin
		prv <= {dac_update_clk_o, adc_clk_o, aux_clock_pin_o, data_clock_pin_o, txrx_select_pin_o};
		n_dac += int'(dac_update_clk_o && !prv[4]);
		n_adc += int'(adc_clk_o && !prv[3]);
		n_aux += int'(aux_clock_pin_o && !prv[2]);
		n_dcp += int'(data_clock_pin_o && !prv[1]);
		n_sel += int'(txrx_select_pin_o && !prv[0]);
		n_lat += int'(tx_data_latch_o === 1'b1);
		n_eq += int'(data_clock_pin_o === adc_clk_o);
		n_ar += int'(aux_clock_pin_o === rx_reference_clock_i);
		cyc++;
		if (cyc == 30000) begin
			errors++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic near(input int n, input int e);
		chk(8'(n >= e - 1 && n <= e + 1), 8'h01);
	endtask : near

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge mclk_i);
		reg_wr_i = 1'b0;
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		@(negedge mclk_i);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(negedge mclk_i);
		reg_rd_i = 1'b0;
		@(negedge mclk_i);
		chk(reg_rdata_o, e);
	endtask : rd

	task automatic cfg(input logic [7:0] i, t, p, s);
		wr(`CDIC_OFS_IFACE_CLK, i);
		wr(`CDIC_OFS_TX_PATH, t);
		wr(`CDIC_OFS_PLL_CLK, p);
		wr(`CDIC_OFS_CLKOUT_SRC, s);
		repeat (60) @(negedge mclk_i);
		{n_dac, n_adc, n_lat, n_aux, n_dcp, n_sel, n_eq, n_ar} = '0;
		repeat (480) @(negedge mclk_i);
	endtask : cfg

	task automatic conclude;
		if (errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_regs;
		logic [5:0] a[4] = '{`CDIC_OFS_IFACE_CLK, `CDIC_OFS_TX_PATH, `CDIC_OFS_PLL_CLK, `CDIC_OFS_CLKOUT_SRC};
		logic [7:0] m[4] = '{8'hfe, 8'h23, 8'hbf, 8'h20};
		foreach (a[k]) rd(a[k], 8'h00);
		foreach (a[k]) wr(a[k], 8'hff);
		wr(6'h02, 8'hff);
		foreach (a[k]) rd(a[k], m[k]);
		rd(6'h02, 8'h00);
	endtask : t_regs

	task automatic t_pll;
		for (int c = 0; c < 5; c++) begin
			wr(`CDIC_OFS_PLL_CLK, 8'(c) | 8'h80);
			repeat (3) @(negedge mclk_i);
			chk({3'h0, pll_factor_o}, 8'h01 << c);
			chk({7'h0, pll_bypass_o}, 8'h01);
		end
	endtask : t_pll

	task automatic t_dac;
		logic [7:0] pv[6] = '{8'h80, 8'h00, 8'h08, 8'h20, 8'h10, 8'h30};
		int dv[6] = '{24, 60, 12, 60, 60, 60};
		int av[6] = '{20, 20, 20, 10, 60, 30};
		foreach (pv[k]) begin
			cfg(8'h00, 8'h01, pv[k], 8'h00);
			near(n_dac, dv[k]);
			near(n_adc, av[k]);
		end
	endtask : t_dac

	task automatic t_txclk;
		logic [7:0] iv[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h10, 8'h08, 8'h40, 8'h20, 8'h28};
		logic [7:0] tv[10] = '{8'h01, 8'h02, 8'h00, 8'h21, 8'h21, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
		int lv[10] = '{12, 6, 24, 12, 24, 24, 12, 24, 24, 24};
		logic ev[10] = '{0, 0, 0, 0, 0, 1, 0, 1, 0, 1};
		foreach (iv[k]) begin
			cfg(iv[k], tv[k], 8'h80, 8'h00);
			near(n_lat, lv[k]);
			chk({7'h0, cfg_error_o}, {7'h0, ev[k]});
		end
	endtask : t_txclk

	task automatic t_pins;
		tx_req = 1'b1;
		cfg(8'h00, 8'h01, 8'h80, 8'h00);
		near(n_dcp, 12);
		chk({6'h0, txrx_select_pin_oe_o, aux_clock_pin_oe_o}, 8'h00);
		tx_req = 1'b0;
		cfg(8'h00, 8'h01, 8'h80, 8'h00);
		near(n_dcp, 20);
		chk(8'(n_eq > 400), 8'h01);
		cfg(8'h02, 8'h01, 8'h80, 8'h00);
		chk(8'(n_eq < 80), 8'h01);
		cfg(8'h04, 8'h01, 8'h80, 8'h00);
		near(n_aux, 20);
		chk(8'(n_ar > 240), 8'h01);
		cfg(8'h04, 8'h01, 8'h80, 8'h20);
		near(n_aux, 24);
		cfg(8'h14, 8'h01, 8'h80, 8'h00);
		near(n_aux, 20);
		chk(8'(n_ar < 240), 8'h01);
		near(n_sel, 12);
		cfg(8'h30, 8'h01, 8'h80, 8'h00);
		chk({7'h0, ref_tie_o}, 8'h01);
		near(n_aux, 12);
	endtask : t_pins

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (3) @(negedge mclk_i);
		rst_n_i = 1'b1;
		t_regs();
		t_pll();
		t_dac();
		t_txclk();
		t_pins();
		rst_n_i = 1'b0;
		repeat (3) @(negedge mclk_i);
		rst_n_i = 1'b1;
		rd(`CDIC_OFS_IFACE_CLK, 8'h00);
		conclude();
	end
endmodule : cdic_tb_top
